// ---- hw/stat_monitor_cfg.svh ----
// Constants of the statistical process monitor: offsets, fields, resets.
// Assumes inclusion by bare name from the monitor module and the assertion checker.
`ifndef STAT_MONITOR_CFG_SVH
`define STAT_MONITOR_CFG_SVH

// Register byte addresses
`define SM_ADDR_CTRL      8'h00
`define SM_ADDR_THRESH    8'h04
`define SM_ADDR_CMD       8'h08
`define SM_ADDR_STATUS    8'h0c
`define SM_ADDR_MEAN      8'h10
`define SM_ADDR_DEV       8'h14
`define SM_ADDR_RATIO     8'h18
`define SM_ADDR_BASE_MEAN 8'h1c
`define SM_ADDR_BASE_DEV  8'h20
`define SM_ADDR_BASE_RAT  8'h24

// Control and command word field positions
`define SM_CTRL_EN        0
`define SM_CTRL_RATIO     1
`define SM_CTRL_ACT_LO    2
`define SM_CTRL_RELEARN   4
`define SM_CTRL_NOISECHK  5
`define SM_CTRL_PER_LO    6
`define SM_CTRL_VSTD_LO   12
`define SM_CTRL_VMEAN_LO  14
`define SM_CMD_ALERT_CLR  0

// Reset values and period clamp limits
`define SM_CTRL_RESET     16'ha0e0
`define SM_THRESH_RESET   16'h1432
`define SM_PERIOD_MIN     6'h01
`define SM_PERIOD_MAX     6'h3c

// Timing and arithmetic
`define SM_CLK_HZ         200000000
`define SM_STAT_PERIOD_S  1
`define SM_SEC_PER_MIN    12'h03c
`define SM_NOISE_FLOOR    16'h0004
`define SM_RATIO_FRAC     12
`define SM_DIV_STEPS      5'h1c

`endif

// ---- hw/stat_monitor_pkg.sv ----
// Types shared by the statistical process monitor.
// Uses no constant of stat_monitor_cfg.svh; widths are written out.
package stat_monitor_pkg;

  // Diagnostic state, read back as 0..3 in this order
  typedef enum logic [1:0] {
    ST_DISABLED, ST_LEARNING, ST_VERIFYING, ST_MONITORING
  } diag_state_t;

  // Action taken on a trip
  typedef enum logic [1:0] {
    ACT_NONE, ACT_UNLATCHED, ACT_LATCHED, ACT_ALARM
  } trip_action_t;

  // One set of statistics
  typedef struct packed {
    logic [15:0] mean;
    logic [15:0] dev;
    logic [15:0] noise_ratio;
  } stat_set_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : stat_monitor_pkg

// ---- hw/stat_monitor.sv ----
// Statistical process monitor: running statistics, baseline state machine,
// trip decision and action outputs. Assumes pressure samples come from
// logic on mclk; the alarm direction switch is an asynchronous pin.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`include "stat_monitor_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module stat_monitor #(
  parameter int TICK_CYCLES = `SM_CLK_HZ * `SM_STAT_PERIOD_S
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [15:0]               pressure,
  input  wire logic                      pressureValid,
  input  wire logic                      alarmSwitchHigh,
  input  wire stat_monitor_pkg::reg_req_t regReq,
  output logic [31:0]                    regRdata,
  output logic                           hartAlert,
  output logic                           loopAlarm,
  output logic                           loopAlarmHigh
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Percent limit from a two-bit verification code; 0 means no check
  function automatic logic [7:0] verifPct(input logic [1:0] code);
    verifPct = {4'h0, code} * 8'h0a;
  endfunction : verifPct

  // True when a rises above b, or with twoSided departs from it, by more than pct percent
  function automatic logic overPct(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic [7:0]  pct,
                                   input logic        twoSided);
    logic [15:0] d;
    d = (a >= b) ? a - b : (twoSided ? b - a : 16'h0000);
    overPct = ({16'h0000, d} * 32'd100) > ({16'h0000, b} * {24'h0, pct});
  endfunction : overPct

  ////////////////////////////////////////////////////////////////////////
  // Registers and pins

  logic [15:0] ctrl_r;
  logic [15:0] thresh_r;
  logic [31:0] regRdata_r;
  logic        swMeta_r;
  logic        swSync_r;
  logic        enable;
  logic        ratioMode;
  logic        relearn;
  logic        noiseChk;
  logic [5:0]  periodMin;
  logic [7:0]  sensPct;
  logic [7:0]  meanChgPct;
  stat_monitor_pkg::trip_action_t action;

  assign enable     = ctrl_r[`SM_CTRL_EN];
  assign ratioMode  = ctrl_r[`SM_CTRL_RATIO];
  assign action     = stat_monitor_pkg::trip_action_t'(
                        ctrl_r[`SM_CTRL_ACT_LO +: 2]);
  assign relearn    = ctrl_r[`SM_CTRL_RELEARN];
  assign noiseChk   = ctrl_r[`SM_CTRL_NOISECHK];
  assign periodMin  = ctrl_r[`SM_CTRL_PER_LO +: 6];
  assign sensPct    = thresh_r[7:0];
  assign meanChgPct = thresh_r[15:8];

  // Alarm direction switch is a pin; two flops before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      swMeta_r <= 1'b0;
      swSync_r <= 1'b0;
    end else begin
      swMeta_r <= alarmSwitchHigh;
      swSync_r <= swMeta_r;
    end
  end

  // Configuration writes; period clamped into one to sixty minutes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= `SM_CTRL_RESET;
      thresh_r <= `SM_THRESH_RESET;
    end else if (regReq.wr) begin
      if (regReq.addr == `SM_ADDR_CTRL) begin
        ctrl_r <= regReq.wdata[15:0];
        if (regReq.wdata[`SM_CTRL_PER_LO +: 6] < `SM_PERIOD_MIN)
          ctrl_r[`SM_CTRL_PER_LO +: 6] <= `SM_PERIOD_MIN;
        else if (regReq.wdata[`SM_CTRL_PER_LO +: 6] > `SM_PERIOD_MAX)
          ctrl_r[`SM_CTRL_PER_LO +: 6] <= `SM_PERIOD_MAX;
      end
      if (regReq.addr == `SM_ADDR_THRESH)
        thresh_r <= regReq.wdata[15:0];
    end
  end

  wire alertClr = regReq.wr && (regReq.addr == `SM_ADDR_CMD) &&
                  regReq.wdata[`SM_CMD_ALERT_CLR];

  ////////////////////////////////////////////////////////////////////////
  // Running statistics; they reach regRdata and, through the trip, hartAlert and loopAlarm

  logic [23:0] meanAcc_r;
  logic [27:0] slowAcc_r;
  logic [23:0] devAcc_r;
  logic [31:0] tickCnt_r;
  logic        tick_r;
  logic [16:0] hp;
  logic [15:0] hpAbs;

  // High-pass: sample minus a very slow average
  always_comb begin
    hp    = {1'b0, pressure} - {1'b0, slowAcc_r[27:12]};
    hpAbs = hp[16] ? 16'(-hp) : hp[15:0];
  end

  // Mean on raw samples, deviation on filtered ones; always running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meanAcc_r <= 24'h000000;
      slowAcc_r <= 28'h0000000;
      devAcc_r  <= 24'h000000;
    end else if (pressureValid) begin
      meanAcc_r <= meanAcc_r + {8'h00, pressure}
                   - {8'h00, meanAcc_r[23:8]};
      slowAcc_r <= slowAcc_r + {12'h000, pressure}
                   - {12'h000, slowAcc_r[27:12]};
      devAcc_r  <= devAcc_r + {8'h00, hpAbs}
                   - {8'h00, devAcc_r[23:8]};
    end
  end

  // One-second cadence as a one-cycle enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 32'h00000000;
      tick_r    <= 1'b0;
    end else if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 32'h00000000;
      tick_r    <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h00000001;
      tick_r    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ratio divider: deviation scaled up, over mean, restoring, 28 steps

  stat_monitor_pkg::stat_set_t cur_r;
  logic [27:0] quo_r;
  logic [16:0] rem_r;
  logic [4:0]  divCnt_r;
  logic        divBusy_r;
  logic        statsReady_r;
  logic [16:0] remShift;
  logic        fits;

  always_comb begin
    remShift = {rem_r[15:0], quo_r[27]};
    fits     = remShift >= {1'b0, cur_r.mean};
  end

  // Snapshot each second, then divide; zero mean reads as full scale
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r        <= '0;
      quo_r        <= 28'h0000000;
      rem_r        <= 17'h00000;
      divCnt_r     <= 5'h00;
      divBusy_r    <= 1'b0;
      statsReady_r <= 1'b0;
    end else begin
      statsReady_r <= 1'b0;
      if (tick_r) begin
        cur_r.mean <= meanAcc_r[23:8];
        cur_r.dev  <= devAcc_r[23:8];
        quo_r      <= {devAcc_r[23:8], `SM_RATIO_FRAC'(0)};
        rem_r      <= 17'h00000;
        divCnt_r   <= 5'h00;
        divBusy_r  <= 1'b1;
      end else if (divBusy_r) begin
        rem_r    <= fits ? remShift - {1'b0, cur_r.mean} : remShift;
        quo_r    <= {quo_r[26:0], fits};
        divCnt_r <= divCnt_r + 5'h01;
        if (divCnt_r == `SM_DIV_STEPS - 5'h01) begin
          divBusy_r    <= 1'b0;
          statsReady_r <= 1'b1;
          if (cur_r.mean == 16'h0000 || (|quo_r[26:15]) || fits &&
              quo_r[15])
            cur_r.noise_ratio <= 16'hffff;
          else
            cur_r.noise_ratio <= {quo_r[14:0], fits};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baseline state machine and decision

  stat_monitor_pkg::diag_state_t state_r;
  stat_monitor_pkg::stat_set_t   first_r;
  stat_monitor_pkg::stat_set_t   base_r;
  logic        baseValid_r;
  logic        enPrev_r;
  logic        trip_r;
  logic [11:0] secCnt_r;
  logic        periodEnd;
  logic        stable;

  always_comb begin
    periodEnd = secCnt_r == 12'({6'h00, periodMin} * `SM_SEC_PER_MIN
                                - 12'h001);
    stable = !(ctrl_r[`SM_CTRL_VSTD_LO +: 2] != 2'b00 &&
               overPct(cur_r.dev, first_r.dev,
                       verifPct(ctrl_r[`SM_CTRL_VSTD_LO +: 2]), 1'b1)) &&
             !(ctrl_r[`SM_CTRL_VMEAN_LO +: 2] != 2'b00 &&
               overPct(cur_r.mean, first_r.mean,
                       verifPct(ctrl_r[`SM_CTRL_VMEAN_LO +: 2]), 1'b1));
  end

  // Learning, verifying and monitoring only while enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= stat_monitor_pkg::ST_DISABLED;
      first_r     <= '0;
      base_r      <= '0;
      baseValid_r <= 1'b0;
      enPrev_r    <= 1'b0;
      trip_r      <= 1'b0;
      secCnt_r    <= 12'h000;
    end else begin
      enPrev_r <= enable;
      if (!enable) begin
        state_r <= stat_monitor_pkg::ST_DISABLED;
        trip_r  <= 1'b0;
      end else if (!enPrev_r) begin
        secCnt_r <= 12'h000;
        if (!relearn && baseValid_r)
          state_r <= stat_monitor_pkg::ST_MONITORING;
        else
          state_r <= stat_monitor_pkg::ST_LEARNING;
      end else if (statsReady_r) begin
        secCnt_r <= periodEnd ? 12'h000 : secCnt_r + 12'h001;
        unique case (state_r)
          stat_monitor_pkg::ST_LEARNING: begin
            // Restart the period while process noise is too quiet
            if (periodEnd &&
                !(noiseChk && cur_r.dev <= `SM_NOISE_FLOOR)) begin
              first_r <= cur_r;
              state_r <= stat_monitor_pkg::ST_VERIFYING;
            end
          end
          stat_monitor_pkg::ST_VERIFYING: begin
            if (periodEnd && stable) begin
              base_r      <= cur_r;
              baseValid_r <= 1'b1;
              state_r     <= stat_monitor_pkg::ST_MONITORING;
            end else if (periodEnd) begin
              first_r <= cur_r;
            end
          end
          stat_monitor_pkg::ST_MONITORING: begin
            if (ratioMode) begin
              trip_r <= overPct(cur_r.noise_ratio, base_r.noise_ratio,
                                sensPct, 1'b0);
            end else if (overPct(cur_r.mean, base_r.mean,
                                 meanChgPct, 1'b1)) begin
              trip_r   <= 1'b0;
              secCnt_r <= 12'h000;
              state_r  <= stat_monitor_pkg::ST_LEARNING;
            end else begin
              trip_r <= overPct(cur_r.dev, base_r.dev,
                                sensPct, 1'b0);
            end
          end
          stat_monitor_pkg::ST_DISABLED: begin
            state_r <= stat_monitor_pkg::ST_LEARNING;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trip actions

  logic latched_r;
  logic hartAlert_r;
  logic loopAlarm_r;
  logic loopHigh_r;

  // Latched alert: set wins over a same-cycle clear; state moves ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      latched_r <= 1'b0;
    else if (trip_r && action == stat_monitor_pkg::ACT_LATCHED)
      latched_r <= 1'b1;
    else if (alertClr)
      latched_r <= 1'b0;
  end

  // None gives nothing; alerts leave the loop alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hartAlert_r <= 1'b0;
      loopAlarm_r <= 1'b0;
      loopHigh_r  <= 1'b0;
    end else begin
      hartAlert_r <= latched_r || (trip_r &&
                     action == stat_monitor_pkg::ACT_UNLATCHED);
      loopAlarm_r <= trip_r &&
                     action == stat_monitor_pkg::ACT_ALARM;
      loopHigh_r  <= swSync_r;
    end
  end

  assign hartAlert     = hartAlert_r;
  assign loopAlarm     = loopAlarm_r;
  assign loopAlarmHigh = loopHigh_r;

  ////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe

  logic [1:0] stateCode;

  always_comb begin
    unique case (state_r)
      stat_monitor_pkg::ST_DISABLED:  stateCode = 2'h0;
      stat_monitor_pkg::ST_LEARNING:  stateCode = 2'h1;
      stat_monitor_pkg::ST_VERIFYING: stateCode = 2'h2;
      stat_monitor_pkg::ST_MONITORING: stateCode = 2'h3;
    endcase
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      regRdata_r <= 32'h00000000;
    else if (regReq.rd) begin
      unique case (regReq.addr)
        `SM_ADDR_CTRL:      regRdata_r <= {16'h0000, ctrl_r};
        `SM_ADDR_THRESH:    regRdata_r <= {16'h0000, thresh_r};
        `SM_ADDR_STATUS:    regRdata_r <= {26'h0, baseValid_r,
                              loopAlarm_r, hartAlert_r, trip_r,
                              stateCode};
        `SM_ADDR_MEAN:      regRdata_r <= {16'h0000, cur_r.mean};
        `SM_ADDR_DEV:       regRdata_r <= {16'h0000, cur_r.dev};
        `SM_ADDR_RATIO:     regRdata_r <= {16'h0000,
                                           cur_r.noise_ratio};
        `SM_ADDR_BASE_MEAN: regRdata_r <= {16'h0000, base_r.mean};
        `SM_ADDR_BASE_DEV:  regRdata_r <= {16'h0000, base_r.dev};
        `SM_ADDR_BASE_RAT:  regRdata_r <= {16'h0000,
                                           base_r.noise_ratio};
        default:            regRdata_r <= 32'h00000000;
      endcase
    end
  end

  assign regRdata = regRdata_r;

endmodule : stat_monitor

`default_nettype wire

// ---- testbench/stat_monitor_assertions.sv ----
// Port checks for the statistical process monitor.
// Assumes the package is compiled ahead of this file; it includes the cfg header itself.
`include "stat_monitor_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module stat_monitor_assertions #(
  parameter int TICK_CYCLES = 64
) (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire logic [15:0]                pressure,
  input wire logic                       pressureValid,
  input wire logic                       alarmSwitchHigh,
  input wire stat_monitor_pkg::reg_req_t regReq,
  input wire logic [31:0]                regRdata,
  input wire logic                       hartAlert,
  input wire logic                       loopAlarm,
  input wire logic                       loopAlarmHigh
);
  logic [1:0] ctrlAct_r;
  logic       ctrlEn_r;
  logic       isMapped;
  logic       clrWr;

  // Shadow of action and enable, seen from CTRL writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlAct_r <= 2'h0;
      ctrlEn_r  <= 1'b0;
    end else if (regReq.wr && regReq.addr == `SM_ADDR_CTRL) begin
      ctrlAct_r <= regReq.wdata[3:2];
      ctrlEn_r  <= regReq.wdata[0];
    end
  end

  // Decoded bus conditions; CMD reads back as unmapped
  assign isMapped = regReq.addr inside {`SM_ADDR_CTRL, `SM_ADDR_THRESH,
    `SM_ADDR_STATUS, `SM_ADDR_MEAN, `SM_ADDR_DEV, `SM_ADDR_RATIO,
    `SM_ADDR_BASE_MEAN, `SM_ADDR_BASE_DEV, `SM_ADDR_BASE_RAT};
  assign clrWr = regReq.wr && regReq.addr == `SM_ADDR_CMD && regReq.wdata[0];

  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Switch steady long enough to cross the two-flop sync
  sequence swSteady;
    $stable(alarmSwitchHigh)[*5];
  endsequence
  // Latched alert up, with no clear long enough to cover clear latency
  sequence latchHeld;
    (ctrlAct_r == 2'h2 && hartAlert && !clrWr)[*6];
  endsequence

  a_reset_quiet: assert property (!$past(rst_n) |->
    !hartAlert && !loopAlarm && !loopAlarmHigh) else $error("out after reset");
  a_dir_follows: assert property (swSteady |->
    loopAlarmHigh == alarmSwitchHigh) else $error("alarm direction");
  a_unmapped_zero: assert property (regReq.rd && !isMapped |=>
    regRdata == 32'h0) else $error("unmapped read not zero");
  a_status_width: assert property (regReq.rd &&
    regReq.addr == `SM_ADDR_STATUS |=> regRdata[31:6] == 26'h0)
    else $error("status upper bits");
  a_stat_width: assert property (regReq.rd &&
    regReq.addr >= `SM_ADDR_MEAN && isMapped |=> regRdata[31:16] == 16'h0)
    else $error("stat upper bits");
  a_alert_no_loop: assert property ($rose(hartAlert) |->
    !$rose(loopAlarm)) else $error("alert moved loop");
  a_latched_holds: assert property (latchHeld |=> hartAlert)
    else $error("latched alert dropped");
  a_none_silent: assert property (ctrlAct_r == 2'h0 &&
    !hartAlert |=> !hartAlert) else $error("alert under no action");
  a_loop_only_alarm: assert property (ctrlAct_r != 2'h3 &&
    $past(ctrlAct_r) != 2'h3 && !loopAlarm |=> !loopAlarm)
    else $error("loop forced without alarm action");
  a_off_no_alarm: assert property ((!ctrlEn_r)[*6] |-> !loopAlarm)
    else $error("loop alarm while disabled");
endmodule : stat_monitor_assertions

bind stat_monitor stat_monitor_assertions #(.TICK_CYCLES(TICK_CYCLES))
  stat_monitor_assertions_inst (.mclk, .rst_n, .pressure, .pressureValid,
  .alarmSwitchHigh, .regReq, .regRdata, .hartAlert, .loopAlarm,
  .loopAlarmHigh);
`default_nettype wire

// ---- testbench/hart_host.sv ----
// Host side of the register port: single-cycle reads and writes.
// Assumes the caller is a bench process clocked by the same mclk.
`timescale 1ns/1ps
`default_nettype none

module hart_host (
  input  wire logic                      mclk,
  input  wire logic [31:0]               regRdata,
  output var stat_monitor_pkg::reg_req_t regReq
);
  // Bus idle at time zero
  initial regReq = '0;

  ////////////////////////////////////////
  // Released lines show inverted values, never the last ones
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    regReq <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : regWrite

  // Data taken in the cycle after the strobe; it holds until the next read
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: ~regReq.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    regReq <= '{addr: ~a, wdata: regReq.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = regRdata;
  endtask : regRead
endmodule : hart_host
`default_nettype wire

// ---- testbench/tb_stat_monitor.sv ----
// Self-checking bench for the statistical process monitor.
// Assumes the checker bind and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin \
  err_count++; $display("[FAIL] %0t %s", $time, msg); end end

module tb_stat_monitor;
  localparam int TICK = 64;
  logic                       mclk;
  logic                       rst_n;
  logic [15:0]                pressure;
  logic                       pressureValid;
  logic                       alarmSwitchHigh;
  logic [15:0]                amp;
  logic [15:0]                lvl;
  logic [31:0]                rdat;
  logic [31:0]                mean;
  logic [31:0]                dev;
  logic [31:0]                regRdata;
  logic                       hartAlert;
  logic                       loopAlarm;
  logic                       loopAlarmHigh;
  stat_monitor_pkg::reg_req_t regReq;
  int                         seed;
  int                         err_count;
  int                         compares;
  int                         n;

  stat_monitor #(.TICK_CYCLES(TICK)) stat_monitor_inst (.mclk, .rst_n,
    .pressure, .pressureValid, .alarmSwitchHigh, .regReq, .regRdata,
    .hartAlert, .loopAlarm, .loopAlarmHigh);
  hart_host hart_host_inst (.mclk, .regRdata, .regReq);

  ////////////////////////////////////////
  // Clock and random noise around a fixed level, one sample per 2 cycles
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    pressure      <= lvl + (16'($random(seed)) & amp) - (amp >> 1);
    pressureValid <= ~pressureValid;
  end

  // Control word: period one minute, noise check on, 20% criteria
  function automatic logic [31:0] ctrlW(logic en, logic [1:0] act, logic rl);
    ctrlW = {16'h0, 4'ha, 6'h01, 1'b1, rl, act, 1'b0, en};
  endfunction : ctrlW

  function automatic logic near(logic [31:0] a, logic [31:0] b, int t);
    near = (a + t >= b) && (b + t >= a);
  endfunction : near

  task automatic ticks(int k);
    repeat (k * TICK) @(posedge mclk);
  endtask : ticks

  task automatic rd(logic [7:0] a);
    hart_host_inst.regRead(a, rdat);
  endtask : rd

  task automatic wr(logic [7:0] a, logic [31:0] d);
    hart_host_inst.regWrite(a, d);
  endtask : wr

  // Let noise act for a while, then sample outputs off the edge;
  // long enough for the deviation average to fall back under threshold
  task automatic burst(logic [15:0] a);
    amp = a;
    ticks(20);
    #1;
  endtask : burst

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Watchdog well beyond the expected run of about 60k cycles
  initial begin
    #450000;
    err_count++;
    $display("[FAIL] %0t watchdog", $time);
    final_report;
  end

  initial begin
    {mclk, rst_n, pressure, pressureValid, alarmSwitchHigh} = '0;
    seed = 88164;
    amp = 16'h003f;
    lvl = 16'h0200;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00); `CHK(rdat, 32'ha0e0, "ctrl reset")
    rd(8'h04); `CHK(rdat, 32'h1432, "thresh reset")
    rd(8'h0c); `CHK(rdat, 32'h0, "status reset")
    wr(8'h30, 32'hffffffff);
    rd(8'h30); `CHK(rdat, 32'h0, "unmapped read")
    rd(8'h08); `CHK(rdat, 32'h0, "cmd read")
    wr(8'h00, 32'ha020);
    rd(8'h00); `CHK(rdat, 32'ha060, "period low clamp")
    wr(8'h00, 32'hafe0);
    rd(8'h00); `CHK(rdat, 32'haf20, "period high clamp")
    $display("test registers done");
    // Statistics run while disabled; slow high-pass average settles
    ticks(640);
    rd(8'h10); mean = rdat;
    rd(8'h14); dev = rdat;
    rd(8'h18);
    `CHK(near(mean, 32'h200, 8), 1'b1, "mean off")
    `CHK(near(dev, 32'h10, 8), 1'b1, "dev off")
    `CHK(near(rdat, dev * 4096 / mean, 16), 1'b1, "ratio off")
    $display("test statistics done");
    wr(8'h00, ctrlW(1'b1, 2'h2, 1'b0));
    rd(8'h0c); `CHK(rdat[1:0], 2'h1, "not learning")
    ticks(56);
    rd(8'h0c); `CHK(rdat[1:0], 2'h1, "left learning early")
    ticks(6);
    rd(8'h0c); `CHK(rdat[1:0], 2'h2, "not verifying")
    n = 0;
    do begin
      ticks(1);
      rd(8'h0c);
      n++;
    end while (rdat[1:0] !== 2'h3 && n < 600);
    `CHK(rdat[1:0], 2'h3, "no monitoring")
    `CHK(rdat[5], 1'b1, "no baseline")
    rd(8'h20); `CHK(near(rdat, 32'h10, 8), 1'b1, "base dev off")
    $display("test baseline done");
    burst(16'h00ff);
    `CHK({hartAlert, loopAlarm}, 2'b10, "latched trip")
    burst(16'h003f);
    `CHK(hartAlert, 1'b1, "latched alert lost")
    wr(8'h00, ctrlW(1'b0, 2'h2, 1'b0));
    rd(8'h0c); `CHK(rdat[1:0], 2'h0, "not disabled")
    wr(8'h00, ctrlW(1'b1, 2'h2, 1'b0));
    rd(8'h0c); `CHK(rdat[1:0], 2'h3, "no resume")
    `CHK(hartAlert, 1'b1, "latch lost on restart")
    wr(8'h08, 32'h1);
    repeat (4) @(posedge mclk);
    #1 `CHK(hartAlert, 1'b0, "alert not cleared")
    $display("test latched done");
    wr(8'h00, ctrlW(1'b1, 2'h1, 1'b0));
    burst(16'h00ff);
    `CHK({hartAlert, loopAlarm}, 2'b10, "unlatched trip")
    burst(16'h003f);
    `CHK(hartAlert, 1'b0, "unlatched stuck")
    $display("test unlatched done");
    // Alarm action run in ratio mode, so the ratio compare is exercised
    @(posedge mclk) alarmSwitchHigh <= 1'b1;
    wr(8'h00, ctrlW(1'b1, 2'h3, 1'b0) | 32'h2);
    burst(16'h00ff);
    `CHK({hartAlert, loopAlarm, loopAlarmHigh}, 3'b011, "alarm")
    @(posedge mclk) alarmSwitchHigh <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 `CHK(loopAlarmHigh, 1'b0, "alarm direction")
    burst(16'h003f);
    `CHK(loopAlarm, 1'b0, "ratio alarm stuck")
    $display("test alarm done");
    wr(8'h00, ctrlW(1'b1, 2'h0, 1'b0));
    burst(16'h00ff);
    `CHK({hartAlert, loopAlarm}, 2'b00, "indication on none")
    rd(8'h0c); `CHK(rdat[2], 1'b1, "no trip under none")
    burst(16'h003f);
    $display("test none done");
    // Level step well past the mean-change limit sends it back to learn
    lvl <= 16'h0300;
    ticks(10);
    rd(8'h0c); `CHK(rdat[2:0], 3'h1, "no relearn on mean")
    $display("test mean shift done");
    wr(8'h00, ctrlW(1'b0, 2'h0, 1'b1));
    wr(8'h00, ctrlW(1'b1, 2'h0, 1'b1));
    rd(8'h0c); `CHK(rdat[1:0], 2'h1, "no relearn")
    $display("test relearn done");
    final_report;
  end
endmodule : tb_stat_monitor
`default_nettype wire
